// file: src/drs_pkg.sv
// Purpose: Shared constants and types of the reference switch controller
// Assumes: APB with 32-bit data, register index times four is the address
// Notes: Reset values and field positions live here only
package drs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_REFS = 8;
  localparam int REF_IDX_W = 3;
  localparam int MASK_W = 4;
  localparam int WAIT_W = 4;
  localparam int RANK_W = 4;
  localparam int INT_W = 3;

  // Register indices; byte address is index times four
  localparam logic [5:0] IDX_FAIL_MASK = 6'h2E;
  localparam logic [5:0] IDX_RESTORE = 6'h2F;
  localparam logic [5:0] IDX_REVERT = 6'h30;
  localparam logic [5:0] IDX_RANK_LOW = 6'h31;
  localparam logic [5:0] IDX_CTRL = 6'h38;
  localparam logic [5:0] IDX_STATUS = 6'h39;
  localparam logic [5:0] IDX_INT_STAT = 6'h3A;
  localparam logic [5:0] IDX_INT_MASK = 6'h3B;
  localparam logic [5:0] IDX_RANK_HIGH = 6'h3C;

  // Reset values
  localparam logic [7:0] RST_FAIL_MASK = 8'h3C;
  localparam logic [3:0] RST_RESTORE = 4'h0;
  localparam logic [7:0] RST_REVERT = 8'h00;
  localparam logic [7:0] RST_RANK_LOW = 8'h10;
  localparam logic [23:0] RST_RANK_HIGH = 24'h765432;
  localparam logic RST_AUTO = 1'b1;
  localparam logic [2:0] RST_INT_MASK = 3'h0;

  // Field positions
  localparam int SW_LSB = 0;
  localparam int HOLD_LSB = 4;
  localparam int IND_SCM = 0;
  localparam int IND_CFM = 1;
  localparam int IND_GST = 2;
  localparam int IND_PFM = 3;
  localparam int STAT_SEL_LSB = 0;
  localparam int STAT_ST_LSB = 4;
  localparam int STAT_QUAL_LSB = 8;

  // Interrupt status bits
  localparam int INT_SWITCH = 0;
  localparam int INT_HOLD = 1;
  localparam int INT_REVERT = 2;

  // One minute of the 40 MHz clock
  localparam longint CLK_HZ = 64'd40_000_000;
  localparam longint MINUTE_S = 64'd60;
  localparam logic [31:0] MINUTE_CYCLES = 32'(CLK_HZ * MINUTE_S);

  typedef enum logic [1:0] {
    ST_FREERUN,
    ST_LOCKED,
    ST_HOLDOVER
  } drs_sel_state_t;

endpackage : drs_pkg

// file: src/drs_tick.sv
// Purpose: Minute tick generator for restore delays
// Assumes: PERIOD counts clock cycles of one minute
// Notes: Tick is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
module drs_tick #(
  parameter logic [31:0] PERIOD = drs_pkg::MINUTE_CYCLES
) (
  input wire logic pclk,     // Bus clock
  input wire logic presetn,  // Async reset, active low
  output logic tick          // One pulse per period
);
  import drs_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } drs_tick_st_t;

  drs_tick_st_t st_ff;
  drs_tick_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == (PERIOD - 32'h1)) begin
      nxt_st.cnt = 32'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule // drs_tick

// file: src/drs_ref_qual.sv
// Purpose: Per-reference qualification with fault_free_delay_field delay
// Assumes: Minute tick is free running and shared by all references
// Notes: First partial minute is discarded so the delay is never short
`timescale 1ns/1ps
module drs_ref_qual #(
  parameter int WAIT_BITS = drs_pkg::WAIT_W
) (
  input wire logic pclk,                    // Bus clock
  input wire logic presetn,                 // Async reset, active low
  input wire logic fail,                    // Masked failure of this input
  input wire logic minute_tick,             // One pulse per minute
  input wire logic [WAIT_BITS-1:0] wait_min, // Fault free delay, minutes
  output logic qualified                    // Usable for selection
);
  import drs_pkg::*;

  typedef struct packed {
    logic [WAIT_BITS:0] cnt;
    logic pending;
    logic qual;
  } drs_qual_st_t;

  drs_qual_st_t st_ff;
  drs_qual_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (fail) begin
      // Restart the whole delay on any fault inside the wait
      nxt_st.pending = 1'b1;
      nxt_st.qual = 1'b0;
      nxt_st.cnt = {1'b0, wait_min} + {{WAIT_BITS{1'b0}}, |wait_min};
    end else if (st_ff.pending) begin
      if (st_ff.cnt == '0) begin
        nxt_st.pending = 1'b0;
        nxt_st.qual = 1'b1;
      end else if (minute_tick) begin
        nxt_st.cnt = st_ff.cnt - {{WAIT_BITS{1'b0}}, 1'b1};
      end
    end else begin
      nxt_st.qual = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign qualified = st_ff.qual;

endmodule // drs_ref_qual

// file: src/drs_ref_switch_ctrl.sv
// Purpose: Automatic reference selection registers and selector, DPLL2
// Assumes: Failure indicators synchronous to pclk, one bit per reference
// Notes: APB slave, zero wait states, unmapped access answers pslverr
`timescale 1ns/1ps
module drs_ref_switch_ctrl #(
  parameter logic [31:0] MINUTE_LEN = drs_pkg::MINUTE_CYCLES
) (
  input wire logic pclk,                                  // APB clock
  input wire logic presetn,                               // Async reset
  input wire logic psel,                                  // APB select
  input wire logic penable,                               // APB enable
  input wire logic pwrite,                                // APB direction
  input wire logic [drs_pkg::ADDR_W-1:0] paddr,           // APB address
  input wire logic [drs_pkg::DATA_W-1:0] pwdata,          // APB write data
  output logic [drs_pkg::DATA_W-1:0] prdata,              // APB read data
  output logic pready,                                    // APB ready
  output logic pslverr,                                   // APB error
  input wire logic [drs_pkg::NUM_REFS-1:0] single_cycle_monitor_fail, // Ind
  input wire logic [drs_pkg::NUM_REFS-1:0] coarse_freq_monitor_fail,  // Ind
  input wire logic [drs_pkg::NUM_REFS-1:0] precise_freq_monitor_fail, // Ind
  input wire logic [drs_pkg::NUM_REFS-1:0] guard_soak_timer_fail,     // Ind
  output logic [drs_pkg::REF_IDX_W-1:0] selected_ref,     // Chosen input
  output logic ref_locked,                                // Locked state
  output logic holdover,                                  // Holdover state
  output logic irq                                        // Level interrupt
);
  import drs_pkg::*;

  typedef struct packed {
    logic [7:0] fail_mask;
    logic [WAIT_W-1:0] restore;
    logic [NUM_REFS-1:0] revert;
    logic [7:0] rank_low;
    logic [23:0] rank_high;
    logic auto_en;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [DATA_W-1:0] rdata;
    logic [REF_IDX_W-1:0] sel;
    drs_sel_state_t st;
  } drs_regs_t;

  drs_regs_t st_ff;
  drs_regs_t nxt_st;

  logic minute_tick;
  logic [NUM_REFS-1:0] sw_fail;
  logic [NUM_REFS-1:0] hold_fail;
  logic [NUM_REFS-1:0] qual;
  logic [RANK_W-1:0] rank [NUM_REFS];
  logic [MASK_W-1:0] sw_mask;
  logic [MASK_W-1:0] hold_mask;
  logic [MASK_W-1:0] ind;
  logic any_qual;
  logic [REF_IDX_W-1:0] best;
  logic [RANK_W-1:0] best_rank;
  logic setup_ph;
  logic access_ph;
  logic [5:0] idx;
  logic mapped;
  logic [DATA_W-1:0] rd_mux;
  logic [INT_W-1:0] events;
  logic [INT_W-1:0] rd_clear;

  drs_tick #(
    .PERIOD(MINUTE_LEN)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(minute_tick)
  );

  assign sw_mask = st_ff.fail_mask[SW_LSB +: MASK_W];
  assign hold_mask = st_ff.fail_mask[HOLD_LSB +: MASK_W];

  // Indicator gating per input
  always_comb begin
    sw_fail = '0;
    hold_fail = '0;
    ind = '0;
    for (int i = 0; i < NUM_REFS; i++) begin
      ind[IND_SCM] = single_cycle_monitor_fail[i];
      ind[IND_CFM] = coarse_freq_monitor_fail[i];
      ind[IND_GST] = guard_soak_timer_fail[i];
      ind[IND_PFM] = precise_freq_monitor_fail[i];
      sw_fail[i] = |(ind & sw_mask);
      hold_fail[i] = |(ind & hold_mask);
    end
  end

  // A hold-gated fault also keeps the input out of selection
  generate
    for (genvar g = 0; g < NUM_REFS; g++) begin : g_qual
      drs_ref_qual #(
        .WAIT_BITS(WAIT_W)
      ) u_qual (
        .pclk(pclk),
        .presetn(presetn),
        .fail(sw_fail[g] | hold_fail[g]),
        .minute_tick(minute_tick),
        .wait_min(st_ff.restore),
        .qualified(qual[g])
      );
    end
  endgenerate

  // Rank codes; inputs 2..7 come from the extra rank register
  always_comb begin
    rank[0] = st_ff.rank_low[RANK_W-1:0];
    rank[1] = st_ff.rank_low[2*RANK_W-1:RANK_W];
    for (int i = 2; i < NUM_REFS; i++) begin
      rank[i] = st_ff.rank_high[(i-2)*RANK_W +: RANK_W];
    end
  end

  // Lowest code wins; ties go to the lower input number
  always_comb begin
    any_qual = 1'b0;
    best = '0;
    best_rank = '1;
    for (int i = 0; i < NUM_REFS; i++) begin
      if (qual[i] && (!any_qual || rank[i] < best_rank)) begin
        any_qual = 1'b1;
        best = REF_IDX_W'(i);
        best_rank = rank[i];
      end
    end
  end

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign idx = paddr[ADDR_W-1:2];

  // Register read decode
  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    case (idx)
      IDX_FAIL_MASK: begin
        rd_mux[7:0] = st_ff.fail_mask;
      end
      IDX_RESTORE: begin
        rd_mux[WAIT_W-1:0] = st_ff.restore;
      end
      IDX_REVERT: begin
        rd_mux[NUM_REFS-1:0] = st_ff.revert;
      end
      IDX_RANK_LOW: begin
        rd_mux[7:0] = st_ff.rank_low;
      end
      IDX_RANK_HIGH: begin
        rd_mux[23:0] = st_ff.rank_high;
      end
      IDX_CTRL: begin
        rd_mux[0] = st_ff.auto_en;
      end
      IDX_STATUS: begin
        rd_mux[STAT_SEL_LSB +: REF_IDX_W] = st_ff.sel;
        rd_mux[STAT_ST_LSB +: 2] = st_ff.st;
        rd_mux[STAT_QUAL_LSB +: NUM_REFS] = qual;
      end
      IDX_INT_STAT: begin
        rd_mux[INT_W-1:0] = st_ff.int_stat;
      end
      IDX_INT_MASK: begin
        rd_mux[INT_W-1:0] = st_ff.int_mask;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Clear only the bits the reader saw, so later events survive
  assign rd_clear = (access_ph && !pwrite && mapped && idx == IDX_INT_STAT)
                    ? st_ff.rdata[INT_W-1:0] : '0;

  // Selection state machine and register writes
  always_comb begin
    nxt_st = st_ff;
    events = '0;

    if (st_ff.auto_en) begin
      case (st_ff.st)
        ST_FREERUN: begin
          if (any_qual) begin
            nxt_st.st = ST_LOCKED;
            nxt_st.sel = best;
          end
        end
        ST_LOCKED: begin
          if (hold_fail[st_ff.sel]) begin
            nxt_st.st = ST_HOLDOVER;
            events[INT_HOLD] = 1'b1;
          end else if (sw_fail[st_ff.sel] || !qual[st_ff.sel]) begin
            if (any_qual) begin
              nxt_st.sel = best;
              events[INT_SWITCH] = 1'b1;
            end else begin
              nxt_st.st = ST_HOLDOVER;
              events[INT_HOLD] = 1'b1;
            end
          end else if (any_qual && best != st_ff.sel &&
                       st_ff.revert[best] &&
                       best_rank < rank[st_ff.sel]) begin
            // Non-revertive inputs are never retaken just for rank
            nxt_st.sel = best;
            events[INT_REVERT] = 1'b1;
          end
        end
        ST_HOLDOVER: begin
          // Held input keeps the loop in holdover until it clears
          if (!hold_fail[st_ff.sel] && any_qual) begin
            nxt_st.st = ST_LOCKED;
            nxt_st.sel = best;
          end
        end
        default: begin
          nxt_st.st = ST_FREERUN;
        end
      endcase
    end

    // Set wins over the read clear
    nxt_st.int_stat = (st_ff.int_stat & ~rd_clear) | events;

    if (setup_ph) begin
      nxt_st.rdata = rd_mux;
    end

    if (access_ph && pwrite && mapped) begin
      case (idx)
        IDX_FAIL_MASK: begin
          nxt_st.fail_mask = pwdata[7:0];
        end
        IDX_RESTORE: begin
          nxt_st.restore = pwdata[WAIT_W-1:0];
        end
        IDX_REVERT: begin
          nxt_st.revert = pwdata[NUM_REFS-1:0];
        end
        IDX_RANK_LOW: begin
          nxt_st.rank_low = pwdata[7:0];
        end
        IDX_RANK_HIGH: begin
          nxt_st.rank_high = pwdata[23:0];
        end
        IDX_CTRL: begin
          nxt_st.auto_en = pwdata[0];
        end
        IDX_INT_MASK: begin
          nxt_st.int_mask = pwdata[INT_W-1:0];
        end
        default: begin
          nxt_st.int_mask = st_ff.int_mask;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.fail_mask <= RST_FAIL_MASK;
      st_ff.restore <= RST_RESTORE;
      st_ff.revert <= RST_REVERT;
      st_ff.rank_low <= RST_RANK_LOW;
      st_ff.rank_high <= RST_RANK_HIGH;
      st_ff.auto_en <= RST_AUTO;
      st_ff.int_stat <= '0;
      st_ff.int_mask <= RST_INT_MASK;
      st_ff.rdata <= '0;
      st_ff.sel <= '0;
      st_ff.st <= ST_FREERUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Zero wait states: read data was captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = st_ff.rdata;
  assign selected_ref = st_ff.sel;
  assign ref_locked = (st_ff.st == ST_LOCKED);
  assign holdover = (st_ff.st == ST_HOLDOVER);
  assign irq = |(st_ff.int_stat & st_ff.int_mask);

endmodule // drs_ref_switch_ctrl

// file: testbench/drs_ref_switch_ctrl_asserts.sv
// Purpose: Port level checks of the reference switch controller
// Assumes: Register mirrors are rebuilt from APB writes at the ports
// Notes: Mirrors keep only the bits that the design stores
`timescale 1ns/1ps
module drs_ref_switch_ctrl_chk import drs_pkg::*; #(
  parameter logic [31:0] MINUTE_LEN = MINUTE_CYCLES
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [ADDR_W-1:0] paddr, // Address
  input wire logic [DATA_W-1:0] pwdata, // Write data
  input wire logic [DATA_W-1:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [NUM_REFS-1:0] single_cycle_monitor_fail, // Ind
  input wire logic [NUM_REFS-1:0] coarse_freq_monitor_fail, // Ind
  input wire logic [NUM_REFS-1:0] precise_freq_monitor_fail, // Ind
  input wire logic [NUM_REFS-1:0] guard_soak_timer_fail, // Ind
  input wire logic [REF_IDX_W-1:0] selected_ref, // Chosen input
  input wire logic ref_locked, // Locked
  input wire logic holdover, // Holdover
  input wire logic irq // Interrupt
);
  logic [7:0] mask_ff;
  logic [7:0] rev_ff;
  logic [7:0] rank_ff;
  logic [3:0] wait_ff;
  logic [7:0] ind [4];
  logic [7:0] sw_v;
  logic [7:0] hd_v;
  logic [DATA_W-1:0] exp_rd;
  logic [5:0] idx;
  logic acc;
  logic cfg;
  logic mapped;
  assign idx = paddr[7:2];
  assign acc = psel && penable;
  assign ind[0] = single_cycle_monitor_fail;
  assign ind[1] = coarse_freq_monitor_fail;
  assign ind[2] = guard_soak_timer_fail;
  assign ind[3] = precise_freq_monitor_fail;
  assign cfg = idx inside {IDX_FAIL_MASK, IDX_RESTORE, IDX_REVERT,
                           IDX_RANK_LOW};
  assign mapped = cfg || (idx inside {[6'h38:6'h3C]});
  always_comb begin
    sw_v = 8'h00;
    hd_v = 8'h00;
    for (int k = 0; k < 4; k++) begin
      sw_v = sw_v | ({8{mask_ff[k]}} & ind[k]);
      hd_v = hd_v | ({8{mask_ff[k+4]}} & ind[k]);
    end
    case (idx)
      IDX_FAIL_MASK: exp_rd = {24'h0, mask_ff};
      IDX_RESTORE: exp_rd = {28'h0, wait_ff};
      IDX_REVERT: exp_rd = {24'h0, rev_ff};
      default: exp_rd = {24'h0, rank_ff};
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= RST_FAIL_MASK;
      wait_ff <= RST_RESTORE;
      rev_ff <= RST_REVERT;
      rank_ff <= RST_RANK_LOW;
    end else if (acc && pwrite) begin
      if (idx == IDX_FAIL_MASK) mask_ff <= pwdata[7:0];
      if (idx == IDX_RESTORE) wait_ff <= pwdata[3:0];
      if (idx == IDX_REVERT) rev_ff <= pwdata[7:0];
      if (idx == IDX_RANK_LOW) rank_ff <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_sel_sw;
    ref_locked && sw_v[selected_ref];
  endsequence
  sequence s_sel_hd;
    ref_locked && hd_v[selected_ref];
  endsequence
  sequence s_leave;
    ##[1:4] ($changed(selected_ref) || holdover);
  endsequence
  property p_sw_fault;
    s_sel_sw |-> s_leave;
  endproperty
  a_sw_fault: assert property (p_sw_fault)
    else $error("selected input kept despite a gated fault");
  property p_hd_fault;
    s_sel_hd |-> ##[1:4] holdover;
  endproperty
  a_hd_fault: assert property (p_hd_fault)
    else $error("no holdover after a hold gated fault");
  property p_hd_stay;
    holdover && hd_v[selected_ref] |=> holdover;
  endproperty
  a_hd_stay: assert property (p_hd_stay)
    else $error("holdover left while the fault remains");
  // Three quiet samples let any earlier fault finish its pipeline
  property p_quiet;
    (ref_locked && (sw_v | hd_v) == 8'h00 && rev_ff == 8'h00)[*3]
      |=> ref_locked && $stable(selected_ref);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("selection moved with all faults masked");
  property p_one_state;
    !(ref_locked && holdover);
  endproperty
  a_one_state: assert property (p_one_state)
    else $error("locked and holdover at once");
  property p_rdback;
    acc && !pwrite && cfg |-> prdata == exp_rd;
  endproperty
  a_rdback: assert property (p_rdback)
    else $error("register read back differs from written value");
  property p_err;
    pslverr == (acc && !mapped);
  endproperty
  a_err: assert property (p_err)
    else $error("error response wrong for this address");
  property p_ready;
    acc |-> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("access phase without ready");
endmodule // drs_ref_switch_ctrl_chk

bind drs_ref_switch_ctrl drs_ref_switch_ctrl_chk #(
  .MINUTE_LEN(MINUTE_LEN)
) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .single_cycle_monitor_fail(single_cycle_monitor_fail),
  .coarse_freq_monitor_fail(coarse_freq_monitor_fail),
  .precise_freq_monitor_fail(precise_freq_monitor_fail),
  .guard_soak_timer_fail(guard_soak_timer_fail),
  .selected_ref(selected_ref), .ref_locked(ref_locked),
  .holdover(holdover), .irq(irq)
);

// file: testbench/drs_ref_src_model.sv
// Purpose: Behavioural monitors of the reference inputs
// Assumes: Bench picks the failing inputs and the reporting monitor
// Notes: Indicators are registered, so they never glitch mid-cycle
`timescale 1ns/1ps
module drs_ref_src_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic [7:0] fault_v, // Failing inputs
  input wire logic [1:0] fault_kind, // Monitor that reports
  output logic [7:0] single_cycle_monitor_fail, // Single cycle
  output logic [7:0] coarse_freq_monitor_fail, // Coarse frequency
  output logic [7:0] guard_soak_timer_fail, // Guard soak
  output logic [7:0] precise_freq_monitor_fail // Precise frequency
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_cycle_monitor_fail <= 8'h00;
      coarse_freq_monitor_fail <= 8'h00;
      guard_soak_timer_fail <= 8'h00;
      precise_freq_monitor_fail <= 8'h00;
    end else begin
      single_cycle_monitor_fail <= (fault_kind == 2'h0) ? fault_v : 8'h00;
      coarse_freq_monitor_fail <= (fault_kind == 2'h1) ? fault_v : 8'h00;
      guard_soak_timer_fail <= (fault_kind == 2'h2) ? fault_v : 8'h00;
      precise_freq_monitor_fail <= (fault_kind == 2'h3) ? fault_v : 8'h00;
    end
  end
endmodule // drs_ref_src_model

// file: testbench/test_drs_ref_switch_ctrl.sv
// Purpose: Self-checking bench of the reference switch controller
// Assumes: A minute is shortened to 20 cycles
// Notes: Table rows cover register access, hand tests the selector
`timescale 1ns/1ps
module test_drs_ref_switch_ctrl;
  import drs_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic e;
  } drs_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic ref_locked, holdover, irq, er;
  logic [7:0] paddr, fault_v;
  logic [7:0] single_cycle_monitor_fail, coarse_freq_monitor_fail;
  logic [7:0] guard_soak_timer_fail, precise_freq_monitor_fail;
  logic [1:0] fault_kind;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] selected_ref, prev;
  int err_count, num_checks, cycles;
  drs_row_t rows [19];

  drs_ref_switch_ctrl #(.MINUTE_LEN(32'h14)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .single_cycle_monitor_fail(single_cycle_monitor_fail),
    .coarse_freq_monitor_fail(coarse_freq_monitor_fail),
    .precise_freq_monitor_fail(precise_freq_monitor_fail),
    .guard_soak_timer_fail(guard_soak_timer_fail),
    .selected_ref(selected_ref), .ref_locked(ref_locked),
    .holdover(holdover), .irq(irq));
  drs_ref_src_model src_u (
    .pclk(pclk), .presetn(presetn), .fault_v(fault_v),
    .fault_kind(fault_kind),
    .single_cycle_monitor_fail(single_cycle_monitor_fail),
    .coarse_freq_monitor_fail(coarse_freq_monitor_fail),
    .guard_soak_timer_fail(guard_soak_timer_fail),
    .precise_freq_monitor_fail(precise_freq_monitor_fail));

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic flt(input logic [7:0] v, input logic [1:0] k);
    @(posedge pclk);
    fault_v <= v;
    fault_kind <= k;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      close_out;
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fault_v, fault_kind, err_count, num_checks, cycles} = '0;
    rows = '{'{1'b0, 8'hB8, 32'h3C, 1'b0}, '{1'b0, 8'hBC, 32'h0, 1'b0},
      '{1'b0, 8'hC0, 32'h0, 1'b0}, '{1'b0, 8'hC4, 32'h10, 1'b0},
      '{1'b1, 8'hB8, 32'h5A, 1'b0}, '{1'b0, 8'hB8, 32'h5A, 1'b0},
      '{1'b1, 8'hBC, 32'hFF, 1'b0}, '{1'b0, 8'hBC, 32'hF, 1'b0},
      '{1'b1, 8'hC0, 32'hA5, 1'b0}, '{1'b0, 8'hC0, 32'hA5, 1'b0},
      '{1'b1, 8'hC4, 32'hF0, 1'b0}, '{1'b0, 8'hC4, 32'hF0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 1'b1}, '{1'b1, 8'h04, 32'h1, 1'b1},
      '{1'b0, 8'hF0, 32'h765432, 1'b0}, '{1'b0, 8'hE4, 32'hFF10, 1'b0},
      '{1'b1, 8'hE0, 32'h0, 1'b0}, '{1'b0, 8'hE0, 32'h0, 1'b0},
      '{1'b1, 8'hE0, 32'h1, 1'b0}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].wr) chk("rdata", rd, rows[i].d);
      chk("slverr", {31'h0, er}, {31'h0, rows[i].e});
    end
    // Reset in mid-run must clear the selection, state and irq outputs and bring back the default fail mask
    @(posedge pclk);
    presetn <= 1'b0;
    settle(2);
    chk("rst_out", {26'h0, selected_ref, ref_locked, holdover, irq}, 0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'hB8, 32'h0, rd, er);
    chk("mask_rst", rd, 32'h3C);
    settle(6);
    chk("lock", {29'h0, selected_ref, ref_locked}, 32'h1);
    apb(1'b1, 8'hEC, 32'h7, rd, er);
    for (int k = 0; k < 4; k++) begin
      prev = selected_ref;
      apb(1'b1, 8'hB8, 32'h1 << k, rd, er);
      flt(8'h01 << prev, 2'(k));
      settle(6);
      chk("sw_sel", {28'h0, selected_ref, ref_locked},
          {28'h0, prev ^ 3'h1, 1'b1});
      flt(8'h00, 2'h0);
      settle(6);
    end
    chk("irq_set", {31'h0, irq}, 32'h1);
    apb(1'b0, 8'hE8, 32'h0, rd, er);
    chk("int_sw", rd, 32'h1);
    settle(1);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'hB8, 32'h38, rd, er);
    flt(8'h01, 2'h2);
    settle(6);
    chk("masked", {28'h0, selected_ref, ref_locked}, 32'h1);
    flt(8'h00, 2'h0);
    apb(1'b1, 8'hB8, 32'h3C, rd, er);
    apb(1'b1, 8'hBC, 32'h2, rd, er);
    flt(8'h02, 2'h2);
    settle(4);
    apb(1'b1, 8'hC4, 32'h0F, rd, er);
    apb(1'b1, 8'hC0, 32'h02, rd, er);
    flt(8'h00, 2'h0);
    settle(30);
    chk("wait_sel", {29'h0, selected_ref}, 32'h0);
    settle(40);
    chk("rev_sel", {29'h0, selected_ref}, 32'h1);
    apb(1'b0, 8'hE8, 32'h0, rd, er);
    chk("int_rev", rd, 32'h4);
    flt(8'h02, 2'h1);
    settle(6);
    chk("hold", {30'h0, ref_locked, holdover}, 32'h1);
    apb(1'b0, 8'hE8, 32'h0, rd, er);
    chk("int_hold", rd, 32'h2);
    flt(8'h00, 2'h0);
    settle(6);
    // Input 1 is still in its restore wait, so input 2 ranks best
    chk("exit", {28'h0, selected_ref, ref_locked}, 32'h5);
    close_out;
  end
endmodule // test_drs_ref_switch_ctrl
